// File: design/uct_pkg.sv
/*
 * Shared constants, field positions and types for the unified cache
 * test-access block. Assumes 32-bit test registers and a 32-bit
 * physical address.
 */
package uct_pkg;
  localparam int SETS      = 4;
  localparam int LINES     = 128;
  localparam int WORDS     = 8;
  localparam int LIDX_W    = 9;
  localparam int WIDX_W    = 12;
  localparam int SET_W     = 2;
  localparam int LINE_W    = 7;
  localparam int WORD_W    = 3;
  localparam int TAG_W     = 20;
  // control register fields
  localparam int CTL_CMD_LSB  = 0;
  localparam int CTL_WORD_LSB = 2;
  localparam int CTL_LINE_LSB = 5;
  localparam int CTL_SET_LSB  = 12;
  // tag/state register fields
  localparam int TS_REC_LSB = 0;
  localparam int TS_LO_LSB  = 4;
  localparam int TS_UP_LSB  = 6;
  localparam int TS_TAG_LSB = 12;
  // physical address fields
  localparam int A_WORD_LSB = 2;
  localparam int A_SECT_BIT = 4;
  localparam int A_LINE_LSB = 5;
  localparam int A_TAG_LSB  = 12;
  localparam logic [8:0]  SWEEP_LAST = 9'h1ff;
  localparam logic [31:0] DATA_RST   = 32'h0000_0000;
  localparam logic [31:0] TS_RST     = 32'h0000_00f0;
  localparam logic [31:0] CTL_RST    = 32'h0000_0003;
  localparam logic [3:0]  REC_RST    = 4'h0;

  typedef enum logic [1:0] {
    MESI_M = 2'b00, MESI_S = 2'b01, MESI_E = 2'b10, MESI_I = 2'b11
  } uct_mesi_t;
  typedef enum logic [1:0] {
    CMD_FLUSH = 2'b00, CMD_WRITE = 2'b01, CMD_READ = 2'b10, CMD_NOP = 2'b11
  } uct_cmd_t;
  typedef enum logic [1:0] {
    SEL_DATA = 2'b00, SEL_TAG = 2'b01, SEL_CTL = 2'b10, SEL_NONE = 2'b11
  } uct_sel_t;
  typedef enum logic [1:0] {
    ACC_FETCH = 2'b00, ACC_READ = 2'b01, ACC_WRITE = 2'b10, ACC_RSVD = 2'b11
  } uct_kind_t;
  typedef enum logic {ST_IDLE = 1'b0, ST_SWEEP = 1'b1} uct_fsm_t;

  typedef struct packed {
    logic        valid;
    uct_kind_t   kind;
    logic [31:0] addr;
    logic [31:0] wdata;
  } uct_req_t;
  typedef struct packed {
    logic        ack;
    logic        hit;
    logic        ext_wr;
    logic [31:0] rdata;
  } uct_rsp_t;
  typedef struct packed {
    logic             hit;
    logic [SET_W-1:0] set;
  } uct_hit_t;
endpackage

// File: design/uct_cache.sv
/*
 * Unified cache tag/state/data store with test-register access and a
 * dual-ported processor side. Assumes one clock, requests held by the
 * pipeline until acknowledged, and misses handled elsewhere.
 */
// Notes on behaviour
// - line is 32 bytes in two 16-byte sectors, each with own state.
// - four sets; each line keeps address bits 31-12 as tag.
// - address bits 11-5 pick the line, bits 4-2 the word.
// - a processor-written line not yet copied out is Modified.
// - write hit on Exclusive finishes locally, no external write.
// - write hit on Shared also raises an external write.
// - two accesses run together when they hit different banks.
// - test operation starts only on control write; command field chooses.
// - control bits 13:12 set, 11:5 line, 4:2 word.
// - command 00 flush, 01 write, 10 read, 11 no change.
// - tag/state bits 7:6 upper, 5:4 lower; 00 M 01 S 10 E 11 I.
// - tag/state bits 3:0 hold recency used for replacement.
// - test write stores data word and tag at selected place.
// - test read loads word, tag, both states and recency.
// - flush visits every line, Modified sectors become Shared.
`timescale 1ns/100ps
module uct_cache (
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic                ce,
  input  wire logic                treg_wr,
  input  wire uct_pkg::uct_sel_t   treg_sel,
  input  wire logic [31:0]         treg_wdata,
  input  wire uct_pkg::uct_req_t   req_a,
  input  wire uct_pkg::uct_req_t   req_b,
  output uct_pkg::uct_rsp_t        rsp_a_q,
  output uct_pkg::uct_rsp_t        rsp_b_q,
  output logic [31:0]              cache_test_data_q,
  output logic [31:0]              cache_test_tag_state_q,
  output logic [31:0]              cache_test_control_q,
  output logic                     sweep_busy_q
);
  import uct_pkg::*;

  // storage: per-sector state, one tag per line
  logic [31:0]      data_mem [0:SETS*LINES*WORDS-1];
  logic [TAG_W-1:0] tag_mem  [0:SETS*LINES-1];
  uct_mesi_t        up_mem   [0:SETS*LINES-1];
  uct_mesi_t        lo_mem   [0:SETS*LINES-1];
  logic [3:0]       rec_mem  [0:SETS*LINES-1];

  uct_fsm_t          state_q;
  logic [LIDX_W-1:0] sweep_q;
  logic              ctl_go;
  uct_cmd_t          ctl_cmd;
  logic [LIDX_W-1:0] t_line;
  logic [WIDX_W-1:0] t_word;
  logic              acc_ok;
  logic              go_a;
  logic              go_b;
  uct_hit_t          hit_a;
  uct_hit_t          hit_b;

  // tag compare across the four sets
  function automatic uct_hit_t lookup(input logic [31:0] a);
    uct_hit_t          r;
    logic [LIDX_W-1:0] ix;
    uct_mesi_t         st;
    r = '0;
    for (int s = 0; s < SETS; s++) begin
      ix = {s[SET_W-1:0], a[A_LINE_LSB +: LINE_W]};
      st = a[A_SECT_BIT] ? up_mem[ix] : lo_mem[ix];
      if (!r.hit && st != MESI_I &&
          tag_mem[ix] == a[A_TAG_LSB +: TAG_W]) begin
        r.hit = 1'b1;
        r.set = s[SET_W-1:0];
      end
    end
    return r;
  endfunction

  function automatic logic [LIDX_W-1:0] lidx(input logic [SET_W-1:0] s,
                                             input logic [31:0] a);
    return {s, a[A_LINE_LSB +: LINE_W]};
  endfunction

  // only a control-register write launches an operation
  assign ctl_go  = ce && treg_wr && treg_sel == SEL_CTL &&
                   state_q == ST_IDLE;
  assign ctl_cmd = uct_cmd_t'(treg_wdata[CTL_CMD_LSB +: 2]);
  assign t_line  = {treg_wdata[CTL_SET_LSB +: SET_W],
                    treg_wdata[CTL_LINE_LSB +: LINE_W]};
  assign t_word  = {t_line, treg_wdata[CTL_WORD_LSB +: WORD_W]};

  // no processor access while sweeping or during a test op
  assign acc_ok = ce && state_q == ST_IDLE && !ctl_go;
  // lookup reads the arrays; an assign would only watch the address
  always_comb begin
    hit_a = lookup(req_a.addr);
    hit_b = lookup(req_b.addr);
  end
  assign go_a   = acc_ok && req_a.valid;
  // port b yields only on a bank clash with port a
  assign go_b   = acc_ok && req_b.valid && !(req_a.valid &&
                  req_a.addr[A_WORD_LSB +: WORD_W] ==
                  req_b.addr[A_WORD_LSB +: WORD_W]);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q      <= ST_IDLE;
      sweep_q      <= '0;
      sweep_busy_q <= 1'b0;
    end else if (ce) begin
      case (state_q)
        ST_IDLE: begin
          if (ctl_go && ctl_cmd == CMD_FLUSH) begin
            state_q      <= ST_SWEEP;
            sweep_q      <= '0;
            sweep_busy_q <= 1'b1;
          end
        end
        ST_SWEEP: begin
          sweep_q <= sweep_q + 9'h001;
          if (sweep_q == SWEEP_LAST) begin
            state_q      <= ST_IDLE;
            sweep_busy_q <= 1'b0;
          end
        end
        default: begin
          state_q      <= ST_IDLE;
          sweep_busy_q <= 1'b0;
        end
      endcase
    end
  end

  // line state and recency; reset leaves every sector invalid
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < SETS*LINES; i++) begin
        up_mem[i]  <= MESI_I;
        lo_mem[i]  <= MESI_I;
        rec_mem[i] <= REC_RST;
      end
    end else if (ce) begin
      if (state_q == ST_SWEEP) begin
        // demote dirty sectors, clean ones untouched
        if (up_mem[sweep_q] == MESI_M)
          up_mem[sweep_q] <= MESI_S;
        if (lo_mem[sweep_q] == MESI_M)
          lo_mem[sweep_q] <= MESI_S;
      end else if (ctl_go && ctl_cmd == CMD_WRITE) begin
        up_mem[t_line]  <= uct_mesi_t'(
                           cache_test_tag_state_q[TS_UP_LSB +: 2]);
        lo_mem[t_line]  <= uct_mesi_t'(
                           cache_test_tag_state_q[TS_LO_LSB +: 2]);
        rec_mem[t_line] <= cache_test_tag_state_q[TS_REC_LSB +: 4];
      end else begin
        // exclusive write hit turns dirty, shared stays shared
        if (go_a && hit_a.hit) begin
          rec_mem[lidx(hit_a.set, req_a.addr)] <= 4'h1 << hit_a.set;
          if (req_a.kind == ACC_WRITE && req_a.addr[A_SECT_BIT] &&
              up_mem[lidx(hit_a.set, req_a.addr)] == MESI_E)
            up_mem[lidx(hit_a.set, req_a.addr)] <= MESI_M;
          if (req_a.kind == ACC_WRITE && !req_a.addr[A_SECT_BIT] &&
              lo_mem[lidx(hit_a.set, req_a.addr)] == MESI_E)
            lo_mem[lidx(hit_a.set, req_a.addr)] <= MESI_M;
        end
        if (go_b && hit_b.hit) begin
          rec_mem[lidx(hit_b.set, req_b.addr)] <= 4'h1 << hit_b.set;
          if (req_b.kind == ACC_WRITE && req_b.addr[A_SECT_BIT] &&
              up_mem[lidx(hit_b.set, req_b.addr)] == MESI_E)
            up_mem[lidx(hit_b.set, req_b.addr)] <= MESI_M;
          if (req_b.kind == ACC_WRITE && !req_b.addr[A_SECT_BIT] &&
              lo_mem[lidx(hit_b.set, req_b.addr)] == MESI_E)
            lo_mem[lidx(hit_b.set, req_b.addr)] <= MESI_M;
        end
      end
    end
  end

  // data and tag arrays, no reset so they map onto RAM
  always_ff @(posedge core_clk) begin
    if (ce) begin
      // test write of one word plus the tag
      if (ctl_go && ctl_cmd == CMD_WRITE) begin
        data_mem[t_word] <= cache_test_data_q;
        tag_mem[t_line]  <= cache_test_tag_state_q[TS_TAG_LSB +: TAG_W];
      end
      if (go_a && hit_a.hit && req_a.kind == ACC_WRITE)
        data_mem[{lidx(hit_a.set, req_a.addr),
                  req_a.addr[A_WORD_LSB +: WORD_W]}] <= req_a.wdata;
      if (go_b && hit_b.hit && req_b.kind == ACC_WRITE)
        data_mem[{lidx(hit_b.set, req_b.addr),
                  req_b.addr[A_WORD_LSB +: WORD_W]}] <= req_b.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rsp_a_q <= '0;
      rsp_b_q <= '0;
    end else if (ce) begin
      rsp_a_q.ack    <= go_a;
      rsp_a_q.hit    <= go_a && hit_a.hit;
      rsp_a_q.rdata  <= data_mem[{lidx(hit_a.set, req_a.addr),
                                  req_a.addr[A_WORD_LSB +: WORD_W]}];
      // shared write hit goes out to memory too
      rsp_a_q.ext_wr <= go_a && req_a.kind == ACC_WRITE && hit_a.hit &&
                        (req_a.addr[A_SECT_BIT] ?
                         up_mem[lidx(hit_a.set, req_a.addr)] :
                         lo_mem[lidx(hit_a.set, req_a.addr)]) == MESI_S;
      rsp_b_q.ack    <= go_b;
      rsp_b_q.hit    <= go_b && hit_b.hit;
      rsp_b_q.rdata  <= data_mem[{lidx(hit_b.set, req_b.addr),
                                  req_b.addr[A_WORD_LSB +: WORD_W]}];
      rsp_b_q.ext_wr <= go_b && req_b.kind == ACC_WRITE && hit_b.hit &&
                        (req_b.addr[A_SECT_BIT] ?
                         up_mem[lidx(hit_b.set, req_b.addr)] :
                         lo_mem[lidx(hit_b.set, req_b.addr)]) == MESI_S;
    end
  end

  // test registers; command 11 leaves all but control untouched
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cache_test_data_q      <= DATA_RST;
      cache_test_tag_state_q <= TS_RST;
      cache_test_control_q   <= CTL_RST;
    end else if (ce) begin
      if (ctl_go)
        cache_test_control_q <= treg_wdata;
      if (treg_wr && treg_sel == SEL_DATA)
        cache_test_data_q <= treg_wdata;
      if (treg_wr && treg_sel == SEL_TAG)
        cache_test_tag_state_q <= treg_wdata;
      // test read fills both registers from one line
      if (ctl_go && ctl_cmd == CMD_READ) begin
        cache_test_data_q      <= data_mem[t_word];
        cache_test_tag_state_q <= {tag_mem[t_line], 4'h0,
                                   up_mem[t_line], lo_mem[t_line],
                                   rec_mem[t_line]};
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  flush_start_a: assert property (
    ctl_go && ctl_cmd == CMD_FLUSH |=> sweep_busy_q && sweep_q == 9'h000)
    else $error("flush did not start sweep");
  flush_end_a: assert property (
    ce && sweep_busy_q && sweep_q == SWEEP_LAST |=> !sweep_busy_q)
    else $error("sweep did not end after last line");
  sweep_stall_a: assert property (
    sweep_busy_q |=> !rsp_a_q.ack && !rsp_b_q.ack)
    else $error("access accepted during sweep");
  flush_demote_a: assert property (
    ce && sweep_busy_q && up_mem[sweep_q] == MESI_M
    |=> up_mem[$past(sweep_q)] == MESI_S)
    else $error("dirty sector not demoted");
  excl_write_a: assert property (
    go_a && hit_a.hit && req_a.kind == ACC_WRITE &&
    (req_a.addr[A_SECT_BIT] ? up_mem[lidx(hit_a.set, req_a.addr)]
                            : lo_mem[lidx(hit_a.set, req_a.addr)]) == MESI_E
    |=> !rsp_a_q.ext_wr && rsp_a_q.ack)
    else $error("exclusive write went external");
  shared_write_a: assert property (
    go_a && hit_a.hit && req_a.kind == ACC_WRITE &&
    lo_mem[lidx(hit_a.set, req_a.addr)] == MESI_S && !req_a.addr[4]
    |=> rsp_a_q.ext_wr)
    else $error("shared write missed external cycle");
  dual_port_a: assert property (
    acc_ok && req_a.valid && req_b.valid &&
    req_a.addr[4:2] != req_b.addr[4:2] |=> rsp_a_q.ack && rsp_b_q.ack)
    else $error("distinct banks not served together");
  test_read_a: assert property (
    ctl_go && ctl_cmd == CMD_READ
    |=> cache_test_data_q == data_mem[$past(t_word)])
    else $error("test read data mismatch");
  cmd_nop_a: assert property (
    ctl_go && ctl_cmd == CMD_NOP && !(treg_sel != SEL_CTL)
    |=> $stable(cache_test_data_q) && $stable(cache_test_tag_state_q))
    else $error("no-op command changed test registers");
  excl_dirty_a: assert property (
    go_a && hit_a.hit && req_a.kind == ACC_WRITE && req_a.addr[A_SECT_BIT] &&
    up_mem[lidx(hit_a.set, req_a.addr)] == MESI_E
    |=> up_mem[lidx($past(hit_a.set), $past(req_a.addr))] == MESI_M)
    else $error("exclusive write hit not marked dirty");
  test_write_a: assert property (
    ctl_go && ctl_cmd == CMD_WRITE
    |=> data_mem[$past(t_word)] == $past(cache_test_data_q))
    else $error("test write data not stored");
  test_tag_a: assert property (
    ctl_go && ctl_cmd == CMD_READ
    |=> cache_test_tag_state_q[TS_TAG_LSB +: TAG_W] == tag_mem[$past(t_line)])
    else $error("test read tag mismatch");
endmodule // uct_cache

// File: sim/tb.sv
/* self-checking bench for uct_cache: test registers and both ports.
   assumes one 200 MHz clock and single-cycle register and port answers. */
`timescale 1ns/100ps
module tb;
  import uct_pkg::*;
  typedef struct packed {
    logic        hit;
    logic        xw;
    logic        d;
    logic [31:0] rd;
  } uct_exp_t;
  typedef struct packed {
    logic [31:0] dat;
    logic [31:0] ts;
  } uct_rd_t;
  logic        core_clk = 0, resetn = 0, ce = 1, treg_wr = 0;
  logic        rd_pend = 0, busy_q;
  uct_sel_t    treg_sel = SEL_NONE;
  logic [31:0] treg_wdata = 32'h0, dat_q, ts_q, ctl_q, d0, d1, d4;
  uct_req_t    req_a = '0, req_b = '0;
  uct_rsp_t    rsp_a_q, rsp_b_q;
  int          mismatches = 0, num_checks = 0, cyc = 0, seed = 50;
  int          na, nb, n, k;
  uct_exp_t    qr[2][$];
  uct_rd_t     qd[$];
  logic [19:0] tg;
  logic [6:0]  ln;
  logic [1:0]  st;
  logic [3:0]  rec;

  uct_cache u_uct_cache (.core_clk(core_clk), .resetn(resetn), .ce(ce),
    .treg_wr(treg_wr), .treg_sel(treg_sel), .treg_wdata(treg_wdata),
    .req_a(req_a), .req_b(req_b), .rsp_a_q(rsp_a_q), .rsp_b_q(rsp_b_q),
    .cache_test_data_q(dat_q), .cache_test_tag_state_q(ts_q),
    .cache_test_control_q(ctl_q), .sweep_busy_q(busy_q));

  always #2.5 core_clk = ~core_clk;

  // hang guard: whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // results are settled by the falling edge
  always @(negedge core_clk) begin
    uct_rsp_t r;
    uct_exp_t e;
    uct_rd_t  x;
    for (int p = 0; p < 2; p++) begin
      r = p ? rsp_b_q : rsp_a_q;
      if (r.ack === 1'b1 && qr[p].size() == 0) check("spare_ack", 1, 0);
      else if (r.ack === 1'b1) begin
        e = qr[p].pop_front();
        check("rsp_flags", 32'({r.hit, r.ext_wr}), 32'({e.hit, e.xw}));
        if (e.d) check("rsp_rdata", r.rdata, e.rd);
      end
    end
    if (rd_pend) begin
      x = qd.pop_front();
      check("test_data", dat_q, x.dat);
      check("tag_state", ts_q, x.ts);
      rd_pend = 0;
    end
  end

  function automatic logic [31:0] ctl(logic [1:0] s, logic [6:0] l,
                                      logic [2:0] w, uct_cmd_t c);
    return {18'h0, s, l, w, c};
  endfunction

  function automatic logic [31:0] tsv(logic [19:0] t, uct_mesi_t u,
                                      uct_mesi_t l, logic [3:0] r);
    return {t, 4'h0, u, l, r};
  endfunction

  function automatic uct_req_t rq(uct_kind_t kd, logic [6:0] l,
                                  logic [2:0] w, logic [31:0] wd);
    return '{1'b1, kd, {tg, l, w, 2'b00}, wd};
  endfunction

  task automatic treg(uct_sel_t s, logic [31:0] v);
    @(posedge core_clk) #1;
    treg_wr = 1;
    treg_sel = s;
    treg_wdata = v;
    @(posedge core_clk) #1;
    treg_wr = 0;
    treg_sel = SEL_NONE;
  endtask

  // tag/state and data first, control last
  task automatic twrite(logic [6:0] l, logic [2:0] w, logic [31:0] t,
                        logic [31:0] v);
    treg(SEL_TAG, t);
    treg(SEL_DATA, v);
    treg(SEL_CTL, ctl(st, l, w, CMD_WRITE));
  endtask

  task automatic tread(logic [6:0] l, logic [2:0] w, logic [31:0] v,
                       logic [31:0] t);
    treg(SEL_CTL, ctl(st, l, w, CMD_READ));
    qd.push_back('{v, t});
    rd_pend = 1;
  endtask

  // requests held until their own ack is seen
  task automatic proc(uct_req_t ra, uct_req_t rb, uct_exp_t ea,
                      uct_exp_t eb);
    if (ra.valid) qr[0].push_back(ea);
    if (rb.valid) qr[1].push_back(eb);
    @(posedge core_clk) #1;
    req_a = ra;
    req_b = rb;
    na = 0;
    nb = 0;
    n = 0;
    while ((req_a.valid || req_b.valid) && n < 2000) begin
      @(posedge core_clk) #1;
      n++;
      if (rsp_a_q.ack === 1'b1 && req_a.valid) begin
        req_a.valid = 0;
        na = n;
      end
      if (rsp_b_q.ack === 1'b1 && req_b.valid) begin
        req_b.valid = 0;
        nb = n;
      end
    end
  endtask

  initial begin
    d0 = $random(seed);
    d1 = $random(seed);
    d4 = $random(seed);
    tg = 20'($random(seed));
    ln = 7'($random(seed));
    st = 2'($random(seed));
    rec = 4'h1 << st;
    repeat (6) @(posedge core_clk);
    #1 resetn = 1;
    check("rst_data", dat_q, 32'h0);
    check("rst_ts", ts_q, 32'h0000_00f0);
    check("rst_ctl", ctl_q, 32'h0000_0003);
    check("rst_busy", 32'(busy_q), 32'h0);
    proc(rq(ACC_READ, ln, 0, 0), '0, '{0, 0, 0, 0}, '0);
    // both lines filled before any sector goes valid
    for (int i = 0; i < 16; i++)
      twrite(ln + 7'(i / 8), 3'(i % 8), tsv(tg, MESI_I, MESI_I, 4'h5),
             $random(seed));
    twrite(ln, 1, tsv(tg, MESI_E, MESI_S, 4'h5), d1);
    twrite(ln, 0, tsv(tg, MESI_E, MESI_S, 4'h5), d0);
    twrite(ln, 4, tsv(tg, MESI_E, MESI_S, 4'h5), d4);
    tread(ln, 1, d1, tsv(tg, MESI_E, MESI_S, 4'h5));
    tread(ln, 4, d4, tsv(tg, MESI_E, MESI_S, 4'h5));
    treg(SEL_DATA, ~d4);
    treg(SEL_CTL, ctl(st, ln, 0, CMD_NOP));
    check("nop_ctl", ctl_q, ctl(st, ln, 0, CMD_NOP));
    check("nop_data", dat_q, ~d4);
    ce = 0;
    treg(SEL_CTL, ctl(st, ln, 2, CMD_READ));
    ce = 1;
    check("ce_low_ctl", ctl_q, ctl(st, ln, 0, CMD_NOP));
    proc(rq(ACC_WRITE, ln, 4, d1 ^ d4), '0, '{1, 0, 0, 0}, '0);
    proc(rq(ACC_WRITE, ln, 0, ~d0), '0, '{1, 1, 0, 0}, '0);
    tread(ln, 4, d1 ^ d4, tsv(tg, MESI_M, MESI_S, rec));
    proc(rq(ACC_READ, ln, 0, 0), rq(ACC_FETCH, ln, 4, 0),
         '{1, 0, 1, ~d0}, '{1, 0, 1, d1 ^ d4});
    check("dual_same_cycle", 32'(na + nb), 32'h2);
    proc(rq(ACC_READ, ln, 0, 0), rq(ACC_READ, ln, 0, 0),
         '{1, 0, 1, ~d0}, '{1, 0, 1, ~d0});
    check("bank_clash", 32'(nb > na), 32'h1);
    twrite(ln + 7'h1, 0, tsv(tg, MESI_E, MESI_M, 4'h0), d0);
    treg(SEL_CTL, ctl(2'h0, 7'h0, 3'h0, CMD_FLUSH));
    fork
      begin
        k = 0;
        while (busy_q === 1'b1 && k < 1000) begin
          @(posedge core_clk) #1;
          k++;
        end
      end
      begin
        treg(SEL_CTL, ctl(st, ln, 0, CMD_NOP));
        proc(rq(ACC_READ, ln, 0, 0), '0, '{1, 0, 1, ~d0}, '0);
      end
    join
    check("sweep_len", 32'(k), 32'd512);
    check("stall_len", 32'(na), 32'd510);
    check("busy_ctl", ctl_q, 32'h0);
    tread(ln, 4, d1 ^ d4, tsv(tg, MESI_S, MESI_S, rec));
    tread(ln + 7'h1, 0, d0, tsv(tg, MESI_E, MESI_S, 4'h0));
    repeat (2) @(posedge core_clk);
    check("queues_left", 32'(qr[0].size() + qr[1].size() + qd.size()), 0);
    test_done();
  end
endmodule // tb
